// ---- core/io_ports.sv ----
// three 8-bit ports and a 4-bit port 3, pull-up gating, wake gates and comparator/timer routing on port 3
// assumes apb master on the system clock; pins synchronous; analog comparators outside
`timescale 1ns/1ps
`include "io_ports_params.svh"

module io_ports
    import io_ports_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // power control
    input wire logic i_stop_enter,
    input wire logic i_stop_recovery,
    output logic o_stop_wake,
    output logic o_cmp_power_en,
    // port pins
    input wire logic [7:0] i_p0,
    input wire logic [7:0] i_p1,
    input wire logic [7:0] i_p2,
    input wire logic [3:0] i_p3,
    output logic [7:0] o_p0,
    output logic [7:0] o_p0_oe,
    output logic [7:0] o_p0_pullup,
    output logic [7:0] o_p1,
    output logic [7:0] o_p1_oe,
    output logic [7:0] o_p1_pullup,
    output logic [7:0] o_p2,
    output logic [7:0] o_p2_oe,
    output logic [7:0] o_p2_pullup,
    output logic [3:0] o_p3,
    // comparators and timers
    input wire logic i_comparator_out_a,
    input wire logic i_comparator_out_b,
    input wire logic i_t8_out,
    input wire logic i_t16_out,
    output logic o_edge_detect_in,
    // interrupts toward the cpu
    output logic o_interrupt_request_zero,
    output logic o_interrupt_request_one,
    output logic o_interrupt_request_two
);

    // open-drain: drive only while data is low
    function automatic logic [7:0] drive_en(input logic [7:0] dir, input logic [7:0] dat, input logic od);
        drive_en = od ? (dir & ~dat) : dir;
    endfunction

    function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] mode);
        case (mode)
            2'h0: edge_hit = prev & ~cur;
            2'h1: edge_hit = ~prev & cur;
            2'h2: edge_hit = prev ^ cur;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    logic [7:0] port_control_reg_r;
    logic [1:0] p0_mode_r;
    logic p1_dir_r;
    logic [7:0] p2_dir_r;
    logic [7:0] p3_mode_r;
    logic [7:0] irq_edge_r;
    logic [8:0] timer_ctl_r;
    logic [7:0] p0_dat_r, p1_dat_r, p2_dat_r;
    logic [2:0] irq_flag_r;
    logic [3:0] p3_s1_r, p3_s2_r, p3_s3_r;
    logic [7:0] p2_s1_r, p2_s2_r;
    pwr_state_e pwr_r;
    logic [31:0] prdata_nxt;

    wire wr_en = i_psel & i_penable & i_pwrite;
    // recovery beats a same-cycle write so port0 and port1 directions always return to input
    wire cfg_wr = wr_en & ~i_stop_recovery;
    wire rd_en = i_psel & ~i_penable & ~i_pwrite;
    wire hit_port_control_reg = i_paddr == `OFS_PORT_CONTROL;
    wire hit_p0m = i_paddr == `OFS_P0_MODE;
    wire hit_p1m = i_paddr == `OFS_P1_MODE;
    wire hit_p2m = i_paddr == `OFS_P2_MODE;
    wire hit_p3m = i_paddr == `OFS_P3_MODE;
    wire hit_edge = i_paddr == `OFS_IRQ_EDGE;
    wire hit_tmr = i_paddr == `OFS_TIMER_CTL;
    wire hit_dout = i_paddr == `OFS_DATA_OUT;
    wire hit_pin = i_paddr == `OFS_PORT_IN;
    wire hit_stat = i_paddr == `OFS_STATUS;
    wire hit_clr = i_paddr == `OFS_IRQ_CLR;
    wire hit_any = hit_port_control_reg | hit_p0m | hit_p1m | hit_p2m | hit_p3m | hit_edge | hit_tmr | hit_dout
                   | hit_pin | hit_stat | hit_clr;

    wire analog_mode = p3_mode_r[`BIT_P3M_ANALOG];
    wire [7:0] p0_dir = {{4{p0_mode_r[1]}}, {4{p0_mode_r[0]}}};
    wire [7:0] p1_dir = {8{p1_dir_r}};
    wire [1:0] edge_mode = irq_edge_r[`BIT_EDGE_HI:`BIT_EDGE_LO];
    wire hit_l1 = edge_hit(p3_s3_r[1], p3_s2_r[1], edge_mode);
    wire hit_l2 = edge_hit(p3_s3_r[2], p3_s2_r[2], edge_mode);
    // line3 falling edge is irq one only in digital mode
    wire hit_l3 = ~analog_mode & p3_s3_r[3] & ~p3_s2_r[3];
    wire p2_or = |p2_s2_r;
    wire p2_and = &p2_s2_r;
    // in analog mode line3 joins the wake sources; lines 1..2 never do then
    wire wake_src = p2_or | ~p2_and | (analog_mode & ~p3_s2_r[3])
                    | (~analog_mode & ~(&p3_s2_r[2:1]));
    wire edge_src = timer_ctl_r[`BIT_TMR_DEMOD_SEL] ? p2_s2_r[0] : p3_s2_r[1];
    wire cmp_route = port_control_reg_r[`BIT_PORT_CONTROL_REG_CMP_OUT];
    wire p34 = cmp_route ? i_comparator_out_a : (timer_ctl_r[0] ? i_t8_out : p0_dat_r[4]);
    wire p35 = timer_ctl_r[1] ? i_t16_out : p0_dat_r[5];
    wire p36 = timer_ctl_r[5:4] == 2'h0 ? p0_dat_r[6] : (timer_ctl_r[4] ? i_t8_out : (p2_and | p2_or));
    wire p37 = cmp_route ? i_comparator_out_b : p0_dat_r[7];
    wire [2:0] irq_clr = (wr_en & hit_clr) ? i_pwdata[2:0] : 3'h0;
    wire [2:0] irq_set = {hit_l1, hit_l3, hit_l2};

    assign prdata_nxt = hit_port_control_reg ? {24'h0, port_control_reg_r} :
                        hit_p0m ? {30'h0, p0_mode_r} :
                        hit_p1m ? {31'h0, p1_dir_r} :
                        hit_p2m ? {24'h0, p2_dir_r} :
                        hit_p3m ? {24'h0, p3_mode_r} :
                        hit_edge ? {24'h0, irq_edge_r} :
                        hit_tmr ? {23'h0, timer_ctl_r} :
                        hit_dout ? {8'h0, p2_dat_r, p1_dat_r, p0_dat_r} :
                        hit_pin ? {4'h0, analog_mode ? 1'b0 : p3_s2_r[3], p3_s2_r[2:0], p2_s2_r, i_p1, i_p0} :
                        hit_stat ? {27'h0, pwr_r == ST_STOP, irq_flag_r, 1'b0} :
                        32'h0;

    // apb: zero wait states, error on unmapped address
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prdata <= 32'h0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            if (rd_en) begin
                o_prdata <= prdata_nxt;
            end
            o_pready <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~hit_any;
        end
    end

    // drive mode bits for all three ports and comparator routing
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            port_control_reg_r <= 8'h0;
        end else if (cfg_wr & hit_port_control_reg) begin
            port_control_reg_r <= i_pwdata[7:0];
        end
    end

    // nibble directions; recovery clears them before any write
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            p0_mode_r <= `RST_P0_MODE;
        end else if (i_stop_recovery) begin
            p0_mode_r <= 2'h0;
        end else if (cfg_wr & hit_p0m) begin
            p0_mode_r <= i_pwdata[1:0];
        end
    end

    // port1 has one direction bit for the whole byte
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            p1_dir_r <= 1'b0;
        end else if (i_stop_recovery) begin
            p1_dir_r <= 1'b0;
        end else if (cfg_wr & hit_p1m) begin
            p1_dir_r <= i_pwdata[0];
        end
    end

    // port2 is left alone by recovery
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            p2_dir_r <= `RST_P2_DIR;
        end else if (cfg_wr & hit_p2m) begin
            p2_dir_r <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            p3_mode_r <= 8'h0;
        end else if (cfg_wr & hit_p3m) begin
            p3_mode_r <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_edge_r <= 8'h0;
        end else if (cfg_wr & hit_edge) begin
            irq_edge_r <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            timer_ctl_r <= 9'h0;
        end else if (cfg_wr & hit_tmr) begin
            timer_ctl_r <= i_pwdata[8:0];
        end
    end

    // one word loads all three data latches at once
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            p0_dat_r <= 8'h0;
        end else if (cfg_wr & hit_dout) begin
            p0_dat_r <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            p1_dat_r <= 8'h0;
        end else if (cfg_wr & hit_dout) begin
            p1_dat_r <= i_pwdata[15:8];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            p2_dat_r <= 8'h0;
        end else if (cfg_wr & hit_dout) begin
            p2_dat_r <= i_pwdata[23:16];
        end
    end

    // three stages so edges never look at the first flop
    // reset to the idle high level so no false edge follows reset
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            p3_s1_r <= 4'hF;
            p3_s2_r <= 4'hF;
            p3_s3_r <= 4'hF;
        end else begin
            p3_s1_r <= i_p3;
            p3_s2_r <= p3_s1_r;
            p3_s3_r <= p3_s2_r;
        end
    end

    // port2 feeds only levels, so two stages are enough
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            p2_s1_r <= 8'h0;
            p2_s2_r <= 8'h0;
        end else begin
            p2_s1_r <= i_p2;
            p2_s2_r <= p2_s1_r;
        end
    end

    // set wins over clear
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_flag_r <= 3'h0;
        end else begin
            irq_flag_r <= (irq_flag_r & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pwr_r <= ST_RUN;
            o_stop_wake <= 1'b0;
        end else begin
            case (pwr_r)
                ST_RUN: begin
                    if (i_stop_enter) pwr_r <= ST_STOP;
                    o_stop_wake <= 1'b0;
                end
                ST_STOP: begin
                    o_stop_wake <= wake_src;
                    if (i_stop_recovery) pwr_r <= ST_RUN;
                end
                default: pwr_r <= ST_RUN;
            endcase
        end
    end

    // pull-ups start on: every line is an input out of reset
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_p0 <= 8'h0;
            o_p0_oe <= 8'h0;
            o_p0_pullup <= 8'hFF;
        end else begin
            o_p0 <= p0_dat_r;
            o_p0_oe <= drive_en(p0_dir, p0_dat_r, port_control_reg_r[`BIT_PORT_CONTROL_REG_P0_OD]);
            o_p0_pullup <= ~p0_dir;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_p1 <= 8'h0;
            o_p1_oe <= 8'h0;
            o_p1_pullup <= 8'hFF;
        end else begin
            o_p1 <= p1_dat_r;
            o_p1_oe <= drive_en(p1_dir, p1_dat_r, port_control_reg_r[`BIT_PORT_CONTROL_REG_P1_OD]);
            o_p1_pullup <= ~p1_dir;
        end
    end

    // one drive choice for every output bit of port2
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_p2 <= 8'h0;
            o_p2_oe <= 8'h0;
            o_p2_pullup <= 8'hFF;
        end else begin
            o_p2 <= p2_dat_r;
            o_p2_oe <= drive_en(p2_dir_r, p2_dat_r, port_control_reg_r[`BIT_PORT_CONTROL_REG_P2_OD]);
            o_p2_pullup <= ~p2_dir_r;
        end
    end

    // comparators drop the cycle stop is requested, not one later
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_p3 <= 4'h0;
            o_cmp_power_en <= 1'b0;
            o_edge_detect_in <= 1'b0;
        end else begin
            o_p3 <= {p37, p36, p35, p34};
            o_cmp_power_en <= analog_mode & (pwr_r == ST_RUN) & ~i_stop_enter;
            o_edge_detect_in <= edge_src;
        end
    end

    // flags stay sticky until software clears them
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_interrupt_request_zero <= 1'b0;
            o_interrupt_request_one <= 1'b0;
            o_interrupt_request_two <= 1'b0;
        end else begin
            o_interrupt_request_zero <= irq_flag_r[0];
            o_interrupt_request_one <= irq_flag_r[1];
            o_interrupt_request_two <= irq_flag_r[2];
        end
    end

endmodule // io_ports

// ---- core/io_ports_params.svh ----
// register offsets, field positions and reset values for the port block
// assumes a 32-bit apb slave with one aligned word per register
`ifndef IO_PORTS_PARAMS_SVH
`define IO_PORTS_PARAMS_SVH
`define OFS_PORT_CONTROL 12'h000
`define OFS_P0_MODE 12'h004
`define OFS_P1_MODE 12'h008
`define OFS_P2_MODE 12'h00C
`define OFS_P3_MODE 12'h010
`define OFS_IRQ_EDGE 12'h014
`define OFS_TIMER_CTL 12'h018
`define OFS_DATA_OUT 12'h01C
`define OFS_PORT_IN 12'h020
`define OFS_STATUS 12'h024
`define OFS_IRQ_CLR 12'h028
`define BIT_PORT_CONTROL_REG_CMP_OUT 0
`define BIT_PORT_CONTROL_REG_P1_OD 1
`define BIT_PORT_CONTROL_REG_P0_OD 2
`define BIT_PORT_CONTROL_REG_P2_OD 3
`define BIT_P3M_ANALOG 1
`define BIT_EDGE_LO 6
`define BIT_EDGE_HI 7
`define BIT_TMR_DEMOD_SEL 8
`define RST_P0_MODE 2'h0
`define RST_P2_DIR 8'h00
`endif

// ---- core/io_ports_pkg.sv ----
// shared types for the port block
// assumes nothing beyond the params header
package io_ports_pkg;
    typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BOTH, EDGE_NONE} edge_mode_e;
    typedef enum logic [1:0] {ST_RUN, ST_STOP} pwr_state_e;
endpackage

// ---- testbench/io_ports_props.sv ----
// concurrent checks on the port block's top-level ports
// assumes one clock domain and a bind onto io_ports
`timescale 1ns/1ps
module io_ports_props (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // bus and power control
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_stop_enter,
    input wire logic i_stop_recovery,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_cmp_power_en,
    // pin drivers
    input wire logic [7:0] o_p0_oe,
    input wire logic [7:0] o_p0_pullup,
    input wire logic [7:0] o_p1_oe,
    input wire logic [7:0] o_p1_pullup,
    input wire logic [7:0] o_p2_oe,
    input wire logic [7:0] o_p2_pullup
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    a_pull_off_p0: assert property ((o_p0_oe & o_p0_pullup) == 8'h00) else $error("p0 pull-up on a driven line");
    a_pull_off_p1: assert property ((o_p1_oe & o_p1_pullup) == 8'h00) else $error("p1 pull-up on a driven line");
    a_pull_off_p2: assert property ((o_p2_oe & o_p2_pullup) == 8'h00) else $error("p2 pull-up on a driven line");
    a_reset_inputs: assert property (!$past(i_arst_n) |-> {o_p0_oe, o_p1_oe, o_p2_oe} == 24'h0)
        else $error("port driving right after reset");
    a_recovery_inputs: assert property (i_stop_recovery |-> ##[1:2] {o_p0_oe, o_p1_oe} == 16'h0)
        else $error("p0/p1 still driving after stop recovery");
    a_stop_cmp_off: assert property (i_stop_enter |-> ##[1:2] !o_cmp_power_en)
        else $error("comparators powered in stop");
    a_ready_access: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready in access");
    a_ready_single: assert property (o_pready |=> !o_pready) else $error("ready longer than one cycle");
    a_err_with_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    cover property (o_pslverr);
    cover property ($fell(o_cmp_power_en));
    cover property (o_p2_oe != 8'h00);
endmodule // io_ports_props
bind io_ports io_ports_props io_ports_props_inst (.*);

// ---- testbench/pin_env.sv ----
// outside circuitry at ports 0..2: bench drivers, pull-ups, floating lines
// assumes the bench enables its own driver only on lines the block leaves free
`timescale 1ns/1ps
module pin_env (
    // clock
    input wire logic i_clk_sys,
    // block drivers
    input wire logic [7:0] o_p0,
    input wire logic [7:0] o_p1,
    input wire logic [7:0] o_p2,
    input wire logic [7:0] o_p0_oe,
    input wire logic [7:0] o_p1_oe,
    input wire logic [7:0] o_p2_oe,
    input wire logic [7:0] o_p0_pullup,
    input wire logic [7:0] o_p1_pullup,
    input wire logic [7:0] o_p2_pullup,
    // outside drivers
    input wire logic [23:0] i_ext,
    input wire logic [23:0] i_ext_en,
    // resolved levels
    output logic [7:0] i_p0,
    output logic [7:0] i_p1,
    output logic [7:0] i_p2
);
    logic [7:0] float_r = 8'h5A;
    // a free line with no pull-up wanders, so no check can lean on it
    always_ff @(posedge i_clk_sys) begin
        float_r <= ~float_r;
    end
    function automatic logic [7:0] lvl(input logic [7:0] d, oe, pu, x, xe);
        return (oe & d) | (~oe & xe & x) | (~oe & ~xe & (pu | float_r));
    endfunction
    assign i_p0 = lvl(o_p0, o_p0_oe, o_p0_pullup, i_ext[7:0], i_ext_en[7:0]);
    assign i_p1 = lvl(o_p1, o_p1_oe, o_p1_pullup, i_ext[15:8], i_ext_en[15:8]);
    assign i_p2 = lvl(o_p2, o_p2_oe, o_p2_pullup, i_ext[23:16], i_ext_en[23:16]);
endmodule // pin_env

// ---- testbench/testbench.sv ----
// self-checking bench: apb master, pin partner, queued bus results
// assumes io_ports, pin_env and the bound checker
`timescale 1ns/1ps
`include "io_ports_params.svh"
module testbench;
    logic i_clk_sys, i_arst_n, i_psel, i_penable, i_pwrite, i_stop_enter, i_stop_recovery;
    logic i_comparator_out_a, i_comparator_out_b, i_t8_out, i_t16_out, o_pready, o_pslverr, o_stop_wake;
    logic o_cmp_power_en, o_edge_detect_in, o_interrupt_request_zero, o_interrupt_request_one, o_interrupt_request_two;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata;
    logic [3:0] i_p3, o_p3;
    logic [7:0] i_p0, i_p1, i_p2, o_p0, o_p1, o_p2, o_p0_oe, o_p1_oe, o_p2_oe, o_p0_pullup, o_p1_pullup, o_p2_pullup, r;
    logic [23:0] i_ext, i_ext_en;
    logic [32:0] exp_q[$];
    int miscompares = 0;
    int tests_run = 0;
    int seed = 11;
    io_ports io_ports_inst (.*);
    pin_env pin_env_inst (.*);
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        exp_q.push_back(e);
        @(posedge i_clk_sys);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        for (n = 0; n < 16 && o_pready !== 1'b1; n++) @(negedge i_clk_sys);
        if (n == 16) begin
            miscompares++;
            stop_test();
        end
        @(posedge i_clk_sys);
        {i_psel, i_penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input int n);
        apb(1'b1, a, d, 33'h0);
        cyc(n);
    endtask
    // the bus watcher: one queued note per completed transfer
    always @(negedge i_clk_sys) begin
        if (i_psel && i_penable && o_pready === 1'b1) chk({o_pslverr, i_pwrite ? 32'h0 : o_prdata}, exp_q.pop_front());
    end
    initial begin
        {i_arst_n, i_psel, i_penable, i_pwrite, i_stop_enter, i_stop_recovery, i_paddr, i_pwdata} = '0;
        {i_comparator_out_a, i_comparator_out_b, i_t8_out, i_t16_out, i_ext, i_ext_en, i_p3} = {52'h0, 4'hF};
        repeat (3) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        cyc(1);
        chk({o_p0_oe, o_p1_oe, o_p2_oe, o_p0_pullup}, 32'hFF);
        apb(1'b0, `OFS_P0_MODE, 0, {31'h0, `RST_P0_MODE});
        wr(`OFS_DATA_OUT, 32'hC3F05A, 0);
        wr(`OFS_P0_MODE, 1, 2);
        chk({o_p0_oe, o_p0_pullup & 8'h0F}, 16'h0F00);
        wr(`OFS_P0_MODE, 2, 2);
        chk(o_p0_oe, 8'hF0);
        wr(`OFS_PORT_CONTROL, 4, 0);
        wr(`OFS_P0_MODE, 3, 1);
        wr(`OFS_P1_MODE, 1, 2);
        chk({o_p0_oe, o_p1_oe}, 16'hA5FF);
        r = $random(seed);
        wr(`OFS_P2_MODE, r, 2);
        chk({o_p2_oe, o_p2_pullup & r}, {r, 8'h0});
        wr(`OFS_PORT_CONTROL, 32'hE, 2);
        chk({o_p1_oe, o_p2_oe}, {8'h0F, r & 8'h3C});
        i_stop_recovery <= 1'b1;
        cyc(0);
        i_stop_recovery <= 1'b0;
        cyc(2);
        chk({o_p0_oe, o_p1_oe, o_p2_oe}, r & 8'h3C);
        wr(`OFS_P2_MODE, 0, 0);
        {i_ext_en, i_ext, i_p3} <= {24'hFFFFFF, 28'($random(seed))};
        cyc(4);
        apb(1'b0, `OFS_PORT_IN, 0, {5'h0, i_p3, i_ext});
        apb(1'b0, 12'hFFC, 0, {1'b1, 32'h0});
        for (int m = 0; m < 3; m++) begin
            i_p3[1] <= 1'b0;
            wr(`OFS_IRQ_EDGE, m << 6, 6);
            wr(`OFS_IRQ_CLR, 7, 0);
            i_p3[1] <= 1'b1;
            cyc(6);
            chk(o_interrupt_request_two, m != 0);
            wr(`OFS_IRQ_CLR, 7, 0);
            i_p3[1] <= 1'b0;
            cyc(6);
            chk(o_interrupt_request_two, m != 1);
        end
        {i_comparator_out_a, i_comparator_out_b, i_t8_out, i_t16_out} <= 4'($random(seed));
        wr(`OFS_PORT_CONTROL, 1, 2);
        chk({o_p3[0], o_p3[3]}, {i_comparator_out_a, i_comparator_out_b});
        wr(`OFS_PORT_CONTROL, 0, 0);
        wr(`OFS_TIMER_CTL, 32'h103, 2);
        chk({o_p3[1:0], o_edge_detect_in}, {i_t16_out, i_t8_out, i_ext[16]});
        i_ext[23:16] <= 8'h01;
        wr(`OFS_P3_MODE, 2, 2);
        chk(o_cmp_power_en, 1'b1);
        i_stop_enter <= 1'b1;
        cyc(0);
        i_stop_enter <= 1'b0;
        cyc(2);
        chk(o_cmp_power_en, 1'b0);
        chk(o_stop_wake, 1'b1);
        stop_test();
    end
endmodule // testbench
